//--- bench/pdc_host_model.sv
`timescale 1ns/100ps
module pdc_host_model
  import pdc_pkg::*;
(
  input  wire logic           clock_in,  // System clock
  output logic                load_out,  // Load strobe
  output logic [CTRL_BITS-1:0] config_out // Config word
);
  initial begin
    load_out = 1'b0;
    config_out = '0;
  end
  task automatic load(input logic [CTRL_BITS-1:0] c);
    @(negedge clock_in);
    config_out = c & ~(128'h1 << 93);
    load_out = 1'b1;
    @(negedge clock_in);
    load_out = 1'b0;
    config_out = ~config_out;
  endtask : load
endmodule : pdc_host_model

//--- bench/pdc_top_chk.sv
`timescale 1ns/100ps
module pdc_top_chk
  import pdc_pkg::*;
(
  input wire logic                 clock_in,          // Clock
  input wire logic                 nrst_in,           // Reset
  input wire logic                 load_in,           // Load
  input wire logic [CTRL_BITS-1:0] config_in,         // Word in
  input wire logic                 sleep_request_pin, // Sleep pin
  input wire logic                 bank_select_pin,   // Bank pin
  input wire logic [CTRL_BITS-1:0] config_out,        // Stored word
  input wire pdc_pll_s             pll_a_out,         // PLL A
  input wire pdc_pll_s             pll_c_out,         // PLL C
  input wire logic [2:0]           pll_off_out,       // PLL off
  input wire logic [3:0]           outdiv_off_out,    // Divider off
  input wire logic [3:0]           tick_out           // Ticks
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  logic [2:0] age;
  logic [2:0] next_age;
  always_comb next_age = (age == 3'h7) ? age : age + 3'h1;
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) age <= 3'h0;
    else age <= next_age;
  end
  a_load_take: assert property (load_in |=> config_out == $past(config_in))
    else $error("config not taken");
  a_cfg_hold: assert property (!load_in |=> $stable(config_out))
    else $error("config changed");
  a_pll_a_map: assert property ($stable(config_out) |->
    pll_a_out == {config_out[7:0], config_out[18:8]}) else $error("pll a fields");
  a_pll_c_bank: assert property (($stable(bank_select_pin) && $stable(config_out))[*6]
    ##0 age == 3'h7 |-> pll_c_out == (bank_select_pin ? {config_out[79:72],
    config_out[90:80]} : {config_out[55:48], config_out[66:56]})) else $error("bank");
  a_pll_off: assert property ((sleep_request_pin && $stable(config_out))[*4]
    ##0 age == 3'h7 |-> pll_off_out == {config_out[69], config_out[45], config_out[21]})
    else $error("pll off");
  a_outdiv_off: assert property ((sleep_request_pin && $stable(config_out))[*4]
    ##0 age == 3'h7 |-> outdiv_off_out == config_out[123:120]) else $error("div off");
  a_unit_wake: assert property ((!sleep_request_pin)[*4] ##0 age == 3'h7
    |-> pll_off_out == 3'h0 && outdiv_off_out == 4'h0) else $error("awake");
  a_tick_off: assert property ((outdiv_off_out & $past(outdiv_off_out) & tick_out) == 4'h0)
    else $error("tick while off");
endmodule : pdc_top_chk
bind pdc_top pdc_top_chk pdc_top_chk_i (.*);

//--- bench/pdc_top_tb.sv
`timescale 1ns/100ps
module pdc_top_tb
  import pdc_pkg::*;
;
  logic clock_in = 0, nrst_in = 0, load_in, slp = 0, bank = 0;
  logic [CTRL_BITS-1:0] cfg_in, cfg_out, c;
  pdc_pll_s pa, pb, pc;
  logic [2:0] po;
  logic [3:0] oo, tk;
  logic [4*MOD_W-1:0] md;
  int bad_count = 0, compares = 0, cyc = 0;
  logic [5:0] mt [16] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h08, 6'h09,
                          6'h0A, 6'h0C, 6'h0F, 6'h10, 6'h12, 6'h14, 6'h19, 6'h32};
  always #20 clock_in = ~clock_in;
  pdc_host_model pdc_host_model_i (.clock_in(clock_in), .load_out(load_in), .config_out(cfg_in));
  pdc_top pdc_top_i (.clock_in(clock_in), .nrst_in(nrst_in), .load_in(load_in),
    .config_in(cfg_in), .sleep_request_pin(slp), .bank_select_pin(bank), .config_out(cfg_out),
    .pll_a_out(pa), .pll_b_out(pb), .pll_c_out(pc), .pll_off_out(po), .outdiv_off_out(oo),
    .modulus_out(md), .tick_out(tk));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [127:0] s, e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task report_and_stop();
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  task w(input int n);
    repeat (n) @(negedge clock_in);
  endtask : w
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task t_fields();
    c = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
    pdc_host_model_i.load(c);
    w(1);
    chk("pll_a_now", pa, {c[7:0], c[18:8]});
    w(59);
    chk("pll_a", pa, {c[7:0], c[18:8]});
    chk("pll_b", pb, {c[31:24], c[42:32]});
    chk("pll_c1", pc, {c[55:48], c[66:56]});
    chk("mod1", md, {mt[c[111:108]], mt[c[107:104]], mt[c[103:100]], mt[c[99:96]]});
    bank = 1;
    w(2);
    chk("bank_sync", pc, {c[55:48], c[66:56]});
    w(58);
    chk("pll_c2", pc, {c[79:72], c[90:80]});
    chk("mod2", md[23:12], {mt[c[119:116]], mt[c[115:112]]});
    bank = 0;
  endtask : t_fields
  task t_table();
    for (int k = 0; k < 16; k++) begin
      c = '0;
      c[99:96] = k[3:0];
      c[103:100] = 4'hF - k[3:0];
      pdc_host_model_i.load(c);
      w(60);
      chk("mod_ab", md[11:0], {mt[15-k], mt[k]});
    end
  endtask : t_table
  task t_sleep();
    c = '0;
    c[7:0] = 8'h5A;
    c[21] = 1'b1;
    c[69] = 1'b1;
    c[121] = 1'b1;
    c[123] = 1'b1;
    pdc_host_model_i.load(c);
    w(6);
    chk("off_idle", {po, oo}, 7'h00);
    slp = 1;
    w(6);
    chk("pll_off", po, 3'h5);
    chk("div_off", oo, 4'hA);
    slp = 0;
    w(6);
    chk("wake", {po, oo}, 7'h00);
    chk("kept", pa.input_divisor, 8'h5A);
  endtask : t_sleep
  task t_ticks();
    logic [7:0] n;
    c = '0;
    c[99:96] = 4'h3;
    c[120] = 1'b1;
    pdc_host_model_i.load(c);
    w(60);
    n = 8'h00;
    repeat (40) begin
      w(1);
      n += {7'h00, tk[0]};
    end
    chk("tick_run", n, 8'h0A);
    slp = 1;
    w(6);
    n = 8'h00;
    repeat (20) begin
      w(1);
      n += {7'h00, tk[0]};
    end
    chk("tick_off", n, 8'h00);
    chk("mod_kept", md[5:0], 6'h04);
    slp = 0;
    w(6);
    n = 8'h00;
    repeat (40) begin
      w(1);
      n += {7'h00, tk[0]};
    end
    chk("tick_wake", n, 8'h0A);
  endtask : t_ticks
  initial begin
    repeat (16) @(negedge clock_in);
    nrst_in = 1;
    w(2);
    chk("cfg_rst", cfg_out, '0);
    chk("mod_rst", md, {4{6'h01}});
    t_fields();
    t_table();
    t_sleep();
    t_ticks();
    report_and_stop();
  end
endmodule : pdc_top_tb

//--- hw/pdc_outdiv.sv
`timescale 1ns/100ps
// One output post divider: cycle-boundary reload, power-down gating
module pdc_outdiv
  import pdc_pkg::*;
(
  input  wire logic              clock_in,   // System clock
  input  wire logic              nrst_in,    // Async reset, low
  input  wire logic [CODE_W-1:0] code_in,    // Modulus code
  input  wire logic              off_in,     // Power this divider off
  output logic [MOD_W-1:0]       modulus_out, // Modulus in use
  output logic                   tick_out    // Divided enable pulse
);

  pdc_state_e       state;
  pdc_state_e       next_state;
  logic [MOD_W-1:0] count;
  logic [MOD_W-1:0] next_count;
  logic [MOD_W-1:0] next_modulus;
  logic             next_tick;

  always_comb begin
    next_state   = state;
    next_count   = count;
    next_modulus = modulus_out;
    next_tick    = 1'b0;
    case (state)
      PDC_RUN: begin
        if (off_in) begin
          next_state = PDC_SLEEP;
          next_count = '0;
        end else if (count + 6'h01 >= modulus_out) begin
          // New code at a cycle boundary; the wake reload is done in PDC_SLEEP
          next_count   = '0;
          next_tick    = 1'b1;
          next_modulus = pdc_modulus(code_in);
        end else begin
          next_count = count + 6'h01;
        end
      end
      PDC_SLEEP: begin
        // Resume with modulus reloaded from code_in
        if (!off_in) begin
          next_state   = PDC_RUN;
          next_modulus = pdc_modulus(code_in);
        end
      end
      default: next_state = PDC_RUN;
    endcase
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state       <= PDC_RUN;
      count       <= '0;
      modulus_out <= 6'h01;
      tick_out    <= 1'b0;
    end else begin
      state       <= next_state;
      count       <= next_count;
      modulus_out <= next_modulus;
      tick_out    <= next_tick;
    end
  end

endmodule : pdc_outdiv

//--- hw/pdc_pkg.sv
package pdc_pkg;

  // Control bit space
  localparam int CTRL_BITS = 128;

  // Field positions (low bit) and widths
  localparam int REFDIV_W    = 8;
  localparam int LOOPDIV_W   = 11;
  localparam int ACNT_W      = 3;
  localparam int MCNT_W      = 8;
  localparam int CODE_W      = 4;
  localparam int MOD_W       = 6;

  localparam int POS_REF_A   = 0;
  localparam int POS_REF_B   = 24;
  localparam int POS_REF_C1  = 48;
  localparam int POS_REF_C2  = 72;
  localparam int POS_LOOP_A  = 8;
  localparam int POS_LOOP_B  = 32;
  localparam int POS_LOOP_C1 = 56;
  localparam int POS_LOOP_C2 = 80;
  localparam int POS_PD_A    = 21;
  localparam int POS_PD_B    = 45;
  localparam int POS_PD_C    = 69;
  localparam int POS_POST_A  = 96;
  localparam int POS_POST_B  = 100;
  localparam int POS_OUTDIV_C_BANK1_CODE = 104;
  localparam int POS_OUTDIV_D_BANK1_CODE = 108;
  localparam int POS_OUTDIV_C_BANK2_CODE = 112;
  localparam int POS_OUTDIV_D_BANK2_CODE = 116;
  localparam int POS_PDO_A   = 120;
  localparam int POS_PDO_B   = 121;
  localparam int POS_PDO_C   = 122;
  localparam int POS_PDO_D   = 123;

  localparam logic [CTRL_BITS-1:0] CTRL_RESET = '0;

  // Output divider sequencing
  typedef enum logic [1:0] {
    PDC_RUN   = 2'b00,
    PDC_SLEEP = 2'b01
  } pdc_state_e;

  // One PLL's decoded setup
  typedef struct packed {
    logic [REFDIV_W-1:0] input_divisor;
    logic [MCNT_W-1:0]   m_count;
    logic [ACNT_W-1:0]   a_count;
  } pdc_pll_s;

  // Modulus table, codes 0..15
  function automatic logic [MOD_W-1:0] pdc_modulus(input logic [CODE_W-1:0] code);
    case (code)
      4'h0:    pdc_modulus = 6'h01;
      4'h1:    pdc_modulus = 6'h02;
      4'h2:    pdc_modulus = 6'h03;
      4'h3:    pdc_modulus = 6'h04;
      4'h4:    pdc_modulus = 6'h05;
      4'h5:    pdc_modulus = 6'h06;
      4'h6:    pdc_modulus = 6'h08;
      4'h7:    pdc_modulus = 6'h09;
      4'h8:    pdc_modulus = 6'h0A;
      4'h9:    pdc_modulus = 6'h0C;
      4'hA:    pdc_modulus = 6'h0F;
      4'hB:    pdc_modulus = 6'h10;
      4'hC:    pdc_modulus = 6'h12;
      4'hD:    pdc_modulus = 6'h14;
      4'hE:    pdc_modulus = 6'h19;
      default: pdc_modulus = 6'h32;
    endcase
  endfunction : pdc_modulus

endpackage : pdc_pkg

//--- hw/pdc_top.sv
`timescale 1ns/100ps
module pdc_top
  import pdc_pkg::*;
(
  input  wire logic                 clock_in,          // 25 MHz system clock
  input  wire logic                 nrst_in,           // Async reset, low
  input  wire logic                 load_in,           // Load config word
  input  wire logic [CTRL_BITS-1:0] config_in,         // Config word from serial port
  input  wire logic                 sleep_request_pin, // Power-down pin
  input  wire logic                 bank_select_pin,   // Bank select pin
  output logic [CTRL_BITS-1:0]      config_out,        // Stored config
  output pdc_pll_s                  pll_a_out,         // PLL A setup
  output pdc_pll_s                  pll_b_out,         // PLL B setup
  output pdc_pll_s                  pll_c_out,         // PLL C setup, active bank
  output logic [2:0]                pll_off_out,       // PLL C,B,A powered off
  output logic [3:0]                outdiv_off_out,    // Dividers D,C,B,A off
  output logic [4*MOD_W-1:0]        modulus_out,       // Moduli D,C,B,A
  output logic [3:0]                tick_out           // Divided enables D,C,B,A
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration store and pin synchronizers
  logic [CTRL_BITS-1:0] next_config;
  logic [1:0]           sleep_sync;
  logic [1:0]           bank_sync;
  logic                 bank;
  logic [1:0]           next_sleep_sync;
  logic [1:0]           next_bank_sync;
  logic                 next_bank;

  function automatic pdc_pll_s pll_field(input logic [CTRL_BITS-1:0] c,
                                         input int ref_pos, input int loop_pos);
    pll_field.input_divisor = c[ref_pos +: REFDIV_W];
    pll_field.a_count       = c[loop_pos +: ACNT_W];
    pll_field.m_count       = c[loop_pos + ACNT_W +: MCNT_W];
  endfunction : pll_field

  always_comb begin
    next_config     = load_in ? config_in : config_out;
    next_sleep_sync = {sleep_sync[0], sleep_request_pin};
    next_bank_sync  = {bank_sync[0], bank_select_pin};
    next_bank       = bank_sync[1];
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      config_out <= CTRL_RESET;
      sleep_sync <= 2'b00;
      bank_sync  <= 2'b00;
      bank       <= 1'b0;
    end else begin
      config_out <= next_config;
      sleep_sync <= next_sleep_sync;
      bank_sync  <= next_bank_sync;
      bank       <= next_bank;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PLL setups; glide handled by the analog loop
  pdc_pll_s next_pll_a;
  pdc_pll_s next_pll_b;
  pdc_pll_s next_pll_c;
  logic [2:0] next_pll_off;

  always_comb begin
    next_pll_a = pll_field(config_out, POS_REF_A, POS_LOOP_A);
    next_pll_b = pll_field(config_out, POS_REF_B, POS_LOOP_B);
    next_pll_c = bank ? pll_field(config_out, POS_REF_C2, POS_LOOP_C2)
                      : pll_field(config_out, POS_REF_C1, POS_LOOP_C1);
    // Setting stays stored while asleep
    next_pll_off = {config_out[POS_PD_C], config_out[POS_PD_B], config_out[POS_PD_A]}
                   & {3{sleep_sync[1]}};
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pll_a_out   <= '0;
      pll_b_out   <= '0;
      pll_c_out   <= '0;
      pll_off_out <= 3'h0;
    end else begin
      pll_a_out   <= next_pll_a;
      pll_b_out   <= next_pll_b;
      pll_c_out   <= next_pll_c;
      pll_off_out <= next_pll_off;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output dividers
  logic [4*CODE_W-1:0] codes;
  logic [3:0]          next_outdiv_off;

  always_comb begin
    codes[0*CODE_W +: CODE_W] = config_out[POS_POST_A +: CODE_W];
    codes[1*CODE_W +: CODE_W] = config_out[POS_POST_B +: CODE_W];
    codes[2*CODE_W +: CODE_W] = bank ? config_out[POS_OUTDIV_C_BANK2_CODE +: CODE_W]
                                     : config_out[POS_OUTDIV_C_BANK1_CODE +: CODE_W];
    codes[3*CODE_W +: CODE_W] = bank ? config_out[POS_OUTDIV_D_BANK2_CODE +: CODE_W]
                                     : config_out[POS_OUTDIV_D_BANK1_CODE +: CODE_W];
    next_outdiv_off = config_out[POS_PDO_D:POS_PDO_A] & {4{sleep_sync[1]}};
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      outdiv_off_out <= 4'h0;
    end else begin
      outdiv_off_out <= next_outdiv_off;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_div
      pdc_outdiv u_div (
        .clock_in    (clock_in),
        .nrst_in     (nrst_in),
        .code_in     (codes[gi*CODE_W +: CODE_W]),
        .off_in      (outdiv_off_out[gi]),
        .modulus_out (modulus_out[gi*MOD_W +: MOD_W]),
        .tick_out    (tick_out[gi])
      );
    end
  endgenerate

endmodule : pdc_top
